// *** hw/pos_pkg.sv ***
package pos_pkg;
  // register map, byte addresses
  localparam logic [3:0] STEER_CTRL_ADDR = 4'h0;
  localparam logic [3:0] UNIT_CTRL_ADDR  = 4'h4;
  localparam logic [3:0] STATUS_ADDR     = 4'h8;
  // steering control fields
  localparam int         STEER_EN_LSB  = 0;
  localparam int         STEER_SYNC_BIT = 4;
  localparam logic [7:0] STEER_WR_MASK = 8'h1f;
  localparam logic [7:0] STEER_RESET   = 8'h01;
  // unit control fields: mode select in 3:0, output config in 7:6
  localparam int         MODE_LSB      = 0;
  localparam int         CFG_LSB       = 6;
  localparam logic [7:0] UNIT_RESET    = 8'h00;
  localparam logic [1:0] MODE_PWM_HI   = 2'h3;
  localparam logic [1:0] CFG_SINGLE    = 2'h0;
  // axi responses
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;
  // instruction cycle is four system clocks
  localparam int         INSTR_CLKS    = 4;
  localparam logic [1:0] INSTR_LAST    = 2'(INSTR_CLKS - 1);
endpackage

// *** hw/pos_steer_if.sv ***
`timescale 1ns/100ps
`default_nettype none
// steering settings passed from the register file to the pin stage
interface pos_steer_if;
  logic [3:0] enable;
  logic       sync_sel;
  logic [3:0] mode;
  logic [1:0] cfg;
  logic [3:0] active;
  modport regs (output enable, output sync_sel, output mode, output cfg, input active);
  modport pins (input enable, input sync_sel, input mode, input cfg, output active);
endinterface
`default_nettype wire

// *** hw/pos_pin_stage.sv ***
`timescale 1ns/100ps
`default_nettype none
module pos_pin_stage (
  // clock and reset
  input  wire logic     ref_clk_i,
  input  wire logic     rstn_i,
  input  wire logic     clk_en_i,
  // settings
  pos_steer_if.pins     cfg_if,
  // timing strobes, same clock
  input  wire logic     period_start_i,
  input  wire logic     instr_edge_i,
  // waveforms
  input  wire logic     pwm_i,
  input  wire logic [3:0] port_i,
  input  wire logic [3:0] normal_i,
  output logic [3:0]    pin_o
);
  logic [3:0] act_q, act_d;
  logic [3:0] pin_q, pin_d;
  logic       steer_ok;
  logic       pol_wave;

  // pick the moment at which a new steering setting lands
  always_comb begin
    act_d = act_q;
    if (cfg_if.sync_sel ? period_start_i : instr_edge_i) begin
      act_d = cfg_if.enable;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      act_q <= pos_pkg::STEER_RESET[3:0];
      pin_q <= 4'h0;
    end else if (clk_en_i) begin
      act_q <= act_d;
      pin_q <= pin_d;
    end
  end

  // steering lives only in mode 11xx with single output config
  assign steer_ok = (cfg_if.mode[3:2] == pos_pkg::MODE_PWM_HI) &&
                    (cfg_if.cfg == pos_pkg::CFG_SINGLE);
  // mode bit 0 alone flips polarity: bit 0 set means active low
  assign pol_wave = pwm_i ^ cfg_if.mode[0];
  assign cfg_if.active = steer_ok ? act_q : 4'h0;

  // per pin: steered wave, or port, or normal routing when inactive
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (!steer_ok) begin
        pin_d[i] = normal_i[i];
      end else if (act_q[i]) begin
        pin_d[i] = pol_wave;
      end else begin
        pin_d[i] = port_i[i];
      end
    end
  end
  assign pin_o = pin_q;
endmodule
`default_nettype wire

// *** hw/pos_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module pos_top (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rstn_i,
  input  wire logic        clk_en_i,
  // axi4-lite write
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // pwm sources, same clock
  input  wire logic        pwm_wave_i,
  input  wire logic        pwm_period_start_i,
  input  wire logic [3:0]  normal_route_i,
  // general purpose port levels from pins
  input  wire logic [3:0]  port_data_i,
  // output pins a..d
  output logic             pwm_out_pin_a_o,
  output logic             pwm_out_pin_b_o,
  output logic             pwm_out_pin_c_o,
  output logic             pwm_out_pin_d_o
);
  pos_steer_if sif ();

  logic [7:0]  steer_q, steer_d;
  logic [7:0]  unit_q, unit_d;
  logic [3:0]  aw_q, aw_d;
  logic        awh_q, awh_d;
  logic [31:0] w_q, w_d;
  logic [3:0]  ws_q, ws_d;
  logic        wh_q, wh_d;
  logic        bv_q, bv_d;
  logic [1:0]  br_q, br_d;
  logic        rv_q, rv_d;
  logic [1:0]  rr_q, rr_d;
  logic [31:0] rd_q, rd_d;
  logic [1:0]  ic_q, ic_d;
  logic [3:0]  p1_q, p2_q, p3_q, pst_q, pst_d;
  logic [3:0]  pin_w;
  logic [32:0] rsel;

  // register read value for an address; unmapped flags an error
  function automatic logic [32:0] rd_val(input logic [3:0] a);
    case (a)
      pos_pkg::STEER_CTRL_ADDR: rd_val = {1'b0, 24'h0, steer_q & pos_pkg::STEER_WR_MASK};
      pos_pkg::UNIT_CTRL_ADDR:  rd_val = {1'b0, 24'h0, unit_q};
      pos_pkg::STATUS_ADDR:     rd_val = {1'b0, 24'h0, pin_w, sif.active};
      default:                  rd_val = {1'b1, 32'h0};
    endcase
  endfunction

  // axi write: take address and data in either order, answer after both
  always_comb begin
    aw_d    = aw_q;
    awh_d   = awh_q;
    w_d     = w_q;
    ws_d    = ws_q;
    wh_d    = wh_q;
    bv_d    = bv_q;
    br_d    = br_q;
    steer_d = steer_q;
    unit_d  = unit_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_d  = s_axi_awaddr;
      awh_d = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_d  = s_axi_wdata;
      ws_d = s_axi_wstrb;
      wh_d = 1'b1;
    end
    if (bv_q && s_axi_bready) begin
      bv_d = 1'b0;
    end
    if (awh_q && wh_q && !bv_q) begin
      awh_d = 1'b0;
      wh_d  = 1'b0;
      bv_d  = 1'b1;
      br_d  = pos_pkg::RESP_OKAY;
      if (aw_q == pos_pkg::STEER_CTRL_ADDR) begin
        // stored even while steering is inactive
        if (ws_q[0]) steer_d = w_q[7:0] & pos_pkg::STEER_WR_MASK;
      end else if (aw_q == pos_pkg::UNIT_CTRL_ADDR) begin
        if (ws_q[0]) unit_d = w_q[7:0];
      end else if (aw_q != pos_pkg::STATUS_ADDR) begin
        br_d = pos_pkg::RESP_SLVERR;
      end
    end
  end
  assign s_axi_awready = !awh_q && !bv_q;
  assign s_axi_wready  = !wh_q && !bv_q;
  assign s_axi_bvalid  = bv_q;
  assign s_axi_bresp   = br_q;

  // axi read: one cycle to answer, held until rready
  always_comb begin
    // a function result cannot be bit-selected, so it lands in rsel first
    rsel = rd_val(s_axi_araddr);
    rv_d = rv_q;
    rr_d = rr_q;
    rd_d = rd_q;
    if (rv_q && s_axi_rready) rv_d = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      rv_d = 1'b1;
      rd_d = rsel[31:0];
      rr_d = rsel[32] ? pos_pkg::RESP_SLVERR : pos_pkg::RESP_OKAY;
    end
  end
  assign s_axi_arready = !rv_q;
  assign s_axi_rvalid  = rv_q;
  assign s_axi_rdata   = rd_q;
  assign s_axi_rresp   = rr_q;

  // instruction cycle divider gives the quarter-rate boundary
  always_comb begin
    ic_d = (ic_q == pos_pkg::INSTR_LAST) ? 2'h0 : ic_q + 2'h1;
  end

  // port levels come from pins: three stages, change accepted on agreement
  always_comb begin
    pst_d = pst_q;
    for (int i = 0; i < 4; i++) begin
      if (p2_q[i] == p3_q[i]) pst_d[i] = p3_q[i];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      steer_q <= pos_pkg::STEER_RESET;
      unit_q  <= pos_pkg::UNIT_RESET;
      aw_q    <= 4'h0;
      awh_q   <= 1'b0;
      w_q     <= 32'h0;
      ws_q    <= 4'h0;
      wh_q    <= 1'b0;
      bv_q    <= 1'b0;
      br_q    <= 2'h0;
      rv_q    <= 1'b0;
      rr_q    <= 2'h0;
      rd_q    <= 32'h0;
      ic_q    <= 2'h0;
      p1_q    <= 4'h0;
      p2_q    <= 4'h0;
      p3_q    <= 4'h0;
      pst_q   <= 4'h0;
    end else if (clk_en_i) begin
      steer_q <= steer_d;
      unit_q  <= unit_d;
      aw_q    <= aw_d;
      awh_q   <= awh_d;
      w_q     <= w_d;
      ws_q    <= ws_d;
      wh_q    <= wh_d;
      bv_q    <= bv_d;
      br_q    <= br_d;
      rv_q    <= rv_d;
      rr_q    <= rr_d;
      rd_q    <= rd_d;
      ic_q    <= ic_d;
      p1_q    <= port_data_i;
      p2_q    <= p1_q;
      p3_q    <= p2_q;
      pst_q   <= pst_d;
    end
  end

  // settings to the pin stage
  assign sif.enable   = steer_q[pos_pkg::STEER_EN_LSB +: 4];
  assign sif.sync_sel = steer_q[pos_pkg::STEER_SYNC_BIT];
  assign sif.mode     = unit_q[pos_pkg::MODE_LSB +: 4];
  assign sif.cfg      = unit_q[pos_pkg::CFG_LSB +: 2];

  pos_pin_stage u_pins (
    .ref_clk_i      (ref_clk_i),
    .rstn_i         (rstn_i),
    .clk_en_i       (clk_en_i),
    .cfg_if         (sif),
    .period_start_i (pwm_period_start_i),
    .instr_edge_i   (ic_q == pos_pkg::INSTR_LAST),
    .pwm_i          (pwm_wave_i),
    .port_i         (pst_q),
    .normal_i       (normal_route_i),
    .pin_o          (pin_w)
  );

  assign pwm_out_pin_a_o = pin_w[0];
  assign pwm_out_pin_b_o = pin_w[1];
  assign pwm_out_pin_c_o = pin_w[2];
  assign pwm_out_pin_d_o = pin_w[3];
endmodule
`default_nettype wire

// *** verif/pos_checker.sv ***
`timescale 1ns/100ps
`default_nettype none
module pos_checker (
  // clock and reset
  input wire logic        ref_clk_i,
  input wire logic        rstn_i,
  // read side
  input wire logic [3:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // write response
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready
);
  logic [3:0] ra_q;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  // address of the read in flight, for per-register checks
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) ra_q <= 4'h0;
    else if (s_axi_arvalid && s_axi_arready) ra_q <= s_axi_araddr;
  end
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data moved");
  a_read_ends: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("read repeated");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response moved");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper bits set");
  a_steer_unimpl: assert property (s_axi_rvalid && ra_q == 4'h0 |-> s_axi_rdata[7:5] == 3'h0)
    else $error("unused steering bits set");
  a_read_resp: assert property (s_axi_rvalid |->
                                s_axi_rresp == ((ra_q == 4'h0 || ra_q == 4'h4 || ra_q == 4'h8) ? 2'h0 : 2'h2))
    else $error("wrong read response");
endmodule
bind pos_top pos_checker pos_checker_i (.*);
`default_nettype wire

// *** verif/pos_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
module pos_bench;
  logic        ref_clk_i = 1'b0, rstn_i = 1'b0, pwm_wave_i = 1'b1, pwm_period_start_i = 1'b0;
  logic        clk_en_i = 1'b1;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h1;
  logic [31:0] s_axi_wdata = 32'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [3:0]  normal_route_i = 4'h6, port_data_i = 4'ha;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, x;
  logic        pwm_out_pin_a_o, pwm_out_pin_b_o, pwm_out_pin_c_o, pwm_out_pin_d_o;
  logic [7:0]  modes [2] = '{8'h0c, 8'h0d};
  logic [3:0]  ens [4] = '{4'hf, 4'h5, 4'ha, 4'h0};
  int          n_errors = 0, total_checks = 0, m, k;
  // 10 mhz clock
  always #50 ref_clk_i = ~ref_clk_i;
  pos_top pos_top_i (.*);
  // pins as d..a and the level expected for a given steered level w
  function automatic logic [31:0] pins();
    return {28'h0, pwm_out_pin_d_o, pwm_out_pin_c_o, pwm_out_pin_b_o, pwm_out_pin_a_o};
  endfunction
  function automatic logic [31:0] ex(logic [3:0] en, logic w);
    return {28'h0, (en & {4{w}}) | (~en & port_data_i)};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: saw %h wanted %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // a bus wait that ran out ends the run
  task automatic bound(input int j);
    if (j == 60) begin
      n_errors++;
      $display("CHECK FAILED at %0t: bus timeout", $time);
      wrap_up();
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] r);
    int j;
    @(posedge ref_clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (j = 0; j < 60; j++) begin
      @(posedge ref_clk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    bound(j);
    chk({30'h0, s_axi_bresp}, {30'h0, r});
  endtask
  task automatic rd(input logic [3:0] a, input logic [1:0] r);
    int j;
    @(posedge ref_clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (j = 0; j < 60; j++) begin
      @(posedge ref_clk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    bound(j);
    x = s_axi_rdata;
    chk({30'h0, s_axi_rresp}, {30'h0, r});
  endtask
  // one-cycle period start, called right after an edge
  task automatic period();
    pwm_period_start_i <= 1'b1;
    @(posedge ref_clk_i);
    pwm_period_start_i <= 1'b0;
    repeat (8) @(posedge ref_clk_i);
  endtask
  initial begin
    repeat (12) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    rd(4'h0, 2'h0);
    chk(x, 32'h01);
    rd(4'h4, 2'h0);
    chk(x, 32'h00);
    wr(4'h0, 8'hff, 2'h0);
    rd(4'h0, 2'h0);
    chk(x, 32'h1f);
    wr(4'hc, 8'h01, 2'h2);
    rd(4'hc, 2'h2);
    $display("test registers done");
    // clear sync, then both polarities and four enable patterns through the fast update
    wr(4'h0, 8'h00, 2'h0);
    period();
    for (m = 0; m < 2; m++) begin
      for (k = 0; k < 4; k++) begin
        wr(4'h4, modes[m], 2'h0);
        wr(4'h0, {4'h0, ens[k]}, 2'h0);
        repeat (10) @(posedge ref_clk_i);
        chk(pins(), ex(ens[k], ~m[0]));
        // wave low too, so a steered pin cannot hide behind its port level
        pwm_wave_i <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        chk(pins(), ex(ens[k], m[0]));
        pwm_wave_i <= 1'b1;
        rd(4'h8, 2'h0);
        chk({28'h0, x[3:0]}, {28'h0, ens[k]});
      end
    end
    $display("test steering done");
    // wrong mode or wrong output config falls back to normal routing
    wr(4'h0, 8'h05, 2'h0);
    wr(4'h4, 8'h08, 2'h0);
    repeat (10) @(posedge ref_clk_i);
    chk(pins(), 32'h6);
    wr(4'h4, 8'h4c, 2'h0);
    repeat (10) @(posedge ref_clk_i);
    chk(pins(), 32'h6);
    rd(4'h0, 2'h0);
    chk(x, 32'h05);
    rd(4'h8, 2'h0);
    chk({28'h0, x[3:0]}, 32'h0);
    wr(4'h4, 8'h0c, 2'h0);
    repeat (10) @(posedge ref_clk_i);
    chk(pins(), ex(4'h5, 1'b1));
    $display("test inactive done");
    // with sync set the new pattern waits for the period start
    wr(4'h0, 8'h13, 2'h0);
    repeat (10) @(posedge ref_clk_i);
    chk(pins(), ex(4'h5, 1'b1));
    period();
    chk(pins(), ex(4'h3, 1'b1));
    $display("test sync done");
    // a low clock enable freezes the pins although the wave moves; no bus traffic meanwhile
    clk_en_i <= 1'b0;
    pwm_wave_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    chk(pins(), ex(4'h3, 1'b1)); // frozen pins
    clk_en_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    chk(pins(), ex(4'h3, 1'b0));
    pwm_wave_i <= 1'b1;
    $display("test enable done");
    wrap_up();
  end
endmodule
`default_nettype wire
